// file: logic/uart_ext_pkg.sv
// constants and carrier types for the serial status/control extension
package uart_ext_pkg;
   // register indices on the plain register port
   localparam logic [2:0] ADDR_STATUS_TWO    = 3'h0;
   localparam logic [2:0] ADDR_CONTROL_THREE = 3'h1;
   localparam logic [2:0] ADDR_EVT_STATUS    = 3'h2;
   localparam logic [2:0] ADDR_EVT_CLEAR     = 3'h3;
   localparam logic [2:0] ADDR_EVT_ENABLE    = 3'h4;
   // serial_status_two field positions
   localparam int S2_LONG_BREAK_FLAG = 7;
   localparam int S2_RX_EDGE_FLAG    = 6;
   localparam int S2_RX_INVERT       = 4;
   localparam int S2_WAKE_IDLE       = 3;
   localparam int S2_LONG_BREAK_GEN  = 2;
   localparam int S2_LONG_BREAK_DET  = 1;
   localparam int S2_RX_ACTIVE       = 0;
   // serial_control_three field positions
   localparam int C3_RX_NINTH  = 7;
   localparam int C3_TX_NINTH  = 6;
   localparam int C3_DIRECTION = 5;
   localparam int C3_TX_INVERT = 4;
   // event register layout
   localparam int EVT_LONG_BREAK = 1;
   localparam int EVT_RX_EDGE    = 0;
   localparam int EVT_BITS       = 2;
   // reset values
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [1:0] RESET_EVT  = 2'h0;
   // bit-time counts
   localparam logic [3:0] FRAME_BITS_8    = 4'hA;
   localparam logic [3:0] FRAME_BITS_9    = 4'hB;
   localparam logic [3:0] BREAK_TX_SHORT  = 4'hA;
   localparam logic [3:0] BREAK_TX_SHORT9 = 4'hB;
   localparam logic [3:0] BREAK_TX_LONG   = 4'hD;
   localparam logic [3:0] BREAK_TX_LONG9  = 4'hE;
   localparam logic [3:0] BREAK_RX_SHORT  = 4'hA;
   localparam logic [3:0] BREAK_RX_SHORT9 = 4'hB;
   localparam logic [3:0] BREAK_RX_LONG   = 4'hB;
   localparam logic [3:0] BREAK_RX_LONG9  = 4'hC;

   // event pulses from the receive shifter core
   typedef struct packed {
      logic       start_valid;
      logic       idle_seen;
      logic       char_done;
      logic       stop_zero;
      logic       ninth;
   } rx_core_t;

   // main status flags that may raise an error interrupt
   typedef struct packed {
      logic       overrun;
      logic       noise;
      logic       framing;
      logic       parity;
   } err_flags_t;

   // break transmitter states
   typedef enum logic [0:0] {
      BRK_IDLE = 1'b0,
      BRK_SEND = 1'b1
   } brk_state_t;
endpackage

// file: logic/uart_status2_control3_logic.sv
// status-two / control-three extension logic of the asynchronous serial port
// What this block does
// - long break with detection enabled sets flag
// - active receive edge sets edge flag
// - receive inversion flips every element received on rx_pin, not single_wire_rx
// - standby idle sets idle only if enabled
// - transmit break 10/11 or 13/14 bits
// - framing check independent of break length select
// - long break detect blocks framing and full
// - break detected at 10/11 or 11/12
// - active flag set on start, cleared idle
// - received ninth bit readable in control three
// - ninth transmit bit loaded with data byte
// - single-wire mode direction bit steers pin
// - transmit inversion flips transmitted output
// - enabled error flags raise interrupt request
// - frame ten bits, eleven in nine-bit mode
// - break is whole character of zeros
//
// Implementation choices: the register offsets and strobed register access.
module uart_status2_control3_logic (
   // clock and reset
   input  wire logic                     mclk,
   input  wire logic                     nrst,
   // register port
   input  wire logic [2:0]               reg_addr,
   input  wire logic [7:0]               reg_wdata,
   input  wire logic                     reg_write,
   input  wire logic                     reg_read,
   output logic      [7:0]               reg_rdata,
   // serial core configuration and timing
   input  wire logic                     baud_tick,
   input  wire logic                     nine_bit_mode,
   input  wire logic                     loop_select,
   input  wire logic                     receive_source,
   input  wire logic                     receiver_standby,
   output logic      [3:0]               frame_bits,
   // receive side
   input  wire logic                     rx_pin,
   output logic                          rx_line,
   input  wire uart_ext_pkg::rx_core_t   rx_core,
   output logic                          framing_fault_set,
   output logic                          receive_buffer_full_set,
   output logic                          idle_flag_set,
   output logic                          break_detected,
   // transmit side
   input  wire logic                     tx_core_bit,
   input  wire logic                     send_break,
   input  wire logic                     data_write,
   input  wire logic [7:0]               data_wdata,
   output logic      [8:0]               tx_load_word,
   output logic                          tx_load,
   output logic                          tx_break_active,
   output logic                          tx_out,
   output logic                          tx_oe,
   input  wire logic                     tx_pin_in,
   output logic                          single_wire_rx,
   // error flags and interrupt
   input  wire uart_ext_pkg::err_flags_t err_flags,
   output logic                          error_irq,
   output logic                          irq
);
   logic       long_break_irq_flag;
   logic       receive_edge_irq_flag;
   logic       receive_invert;
   logic       wake_idle_detect;
   logic       long_break_generate;
   logic       long_break_detect_enable;
   logic       receiver_active_flag;
   logic       rx_ninth_bit;
   logic       tx_ninth_bit;
   logic       single_wire_direction;
   logic       transmit_invert;
   logic [3:0] err_enable_reg;
   logic [uart_ext_pkg::EVT_BITS-1:0] evt_status_reg;
   logic [uart_ext_pkg::EVT_BITS-1:0] evt_enable_reg;
   logic [uart_ext_pkg::EVT_BITS-1:0] evt_set;
   logic       wr_s2;
   logic       wr_c3;
   logic       rx_prev_reg;
   logic       rx_edge;
   logic [3:0] low_cnt_reg;
   logic [3:0] rx_threshold;
   logic       break_seen;
   logic [3:0] brk_len;
   logic [3:0] brk_cnt_reg;
   logic       single_wire;
   uart_ext_pkg::brk_state_t brk_state;

   assign wr_s2 = reg_write && reg_addr == uart_ext_pkg::ADDR_STATUS_TWO;
   assign wr_c3 = reg_write && reg_addr == uart_ext_pkg::ADDR_CONTROL_THREE;

   // character frame length handed to the shifters
   assign frame_bits = nine_bit_mode ? uart_ext_pkg::FRAME_BITS_9
                                     : uart_ext_pkg::FRAME_BITS_8;

   // control fields of both registers
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         receive_invert           <= 1'b0;
         wake_idle_detect         <= 1'b0;
         long_break_generate      <= 1'b0;
         long_break_detect_enable <= 1'b0;
         tx_ninth_bit             <= 1'b0;
         single_wire_direction    <= 1'b0;
         transmit_invert          <= 1'b0;
         err_enable_reg           <= 4'h0;
      end else begin
         if (wr_s2) begin
            receive_invert           <= reg_wdata[uart_ext_pkg::S2_RX_INVERT];
            wake_idle_detect         <= reg_wdata[uart_ext_pkg::S2_WAKE_IDLE];
            long_break_generate      <= reg_wdata[uart_ext_pkg::S2_LONG_BREAK_GEN];
            long_break_detect_enable <= reg_wdata[uart_ext_pkg::S2_LONG_BREAK_DET];
         end
         if (wr_c3) begin
            tx_ninth_bit          <= reg_wdata[uart_ext_pkg::C3_TX_NINTH];
            single_wire_direction <= reg_wdata[uart_ext_pkg::C3_DIRECTION];
            transmit_invert       <= reg_wdata[uart_ext_pkg::C3_TX_INVERT];
            err_enable_reg        <= reg_wdata[3:0];
         end
      end
   end

   // receive polarity applies to data, start, stop, break and idle alike
   assign rx_line = rx_pin ^ receive_invert;

   // active edge is a fall of the corrected line; a polarity change may fake one
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst)
         rx_prev_reg <= 1'b1;
      else
         rx_prev_reg <= rx_line;
   end
   assign rx_edge = rx_prev_reg && !rx_line;

   // low-time counter in bit times, saturating so a break fires only once
   always_comb begin
      if (long_break_detect_enable)
         rx_threshold = nine_bit_mode ? uart_ext_pkg::BREAK_RX_LONG9
                                      : uart_ext_pkg::BREAK_RX_LONG;
      else
         rx_threshold = nine_bit_mode ? uart_ext_pkg::BREAK_RX_SHORT9
                                      : uart_ext_pkg::BREAK_RX_SHORT;
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst)
         low_cnt_reg <= 4'h0;
      else if (rx_line)
         low_cnt_reg <= 4'h0;
      else if (baud_tick && low_cnt_reg != 4'hF)
         low_cnt_reg <= low_cnt_reg + 4'h1;
   end
   assign break_seen     = baud_tick && !rx_line && low_cnt_reg == rx_threshold - 4'h1;
   assign break_detected = break_seen;

   // w1c flags; a new event in the clearing cycle wins
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         long_break_irq_flag   <= 1'b0;
         receive_edge_irq_flag <= 1'b0;
      end else begin
         if (break_seen && long_break_detect_enable)
            long_break_irq_flag <= 1'b1;
         else if (wr_s2 && reg_wdata[uart_ext_pkg::S2_LONG_BREAK_FLAG])
            long_break_irq_flag <= 1'b0;
         if (rx_edge)
            receive_edge_irq_flag <= 1'b1;
         else if (wr_s2 && reg_wdata[uart_ext_pkg::S2_RX_EDGE_FLAG])
            receive_edge_irq_flag <= 1'b0;
      end
   end

   // receiver active flag, set wins over the idle clear
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst)
         receiver_active_flag <= 1'b0;
      else if (rx_core.start_valid)
         receiver_active_flag <= 1'b1;
      else if (rx_core.idle_seen)
         receiver_active_flag <= 1'b0;
   end

   // flag gating toward the main status register; stop check ignores break length
   assign framing_fault_set       = rx_core.char_done && rx_core.stop_zero
                                    && !long_break_detect_enable;
   assign receive_buffer_full_set = rx_core.char_done && !long_break_detect_enable;
   assign idle_flag_set           = rx_core.idle_seen
                                    && (!receiver_standby || wake_idle_detect);

   // ninth received bit follows the buffered byte; software reads it first
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst)
         rx_ninth_bit <= 1'b0;
      else if (receive_buffer_full_set && nine_bit_mode)
         rx_ninth_bit <= rx_core.ninth;
   end

   // shifter load word: held ninth bit joins every data write in nine-bit mode, zero in eight-bit mode
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         tx_load_word <= 9'h000;
         tx_load      <= 1'b0;
      end else begin
         tx_load <= data_write;
         if (data_write)
            tx_load_word <= {nine_bit_mode & tx_ninth_bit, data_wdata};
      end
   end

   // break length is latched at start so a mid-break change cannot cut it
   always_comb begin
      if (long_break_generate)
         brk_len = nine_bit_mode ? uart_ext_pkg::BREAK_TX_LONG9
                                 : uart_ext_pkg::BREAK_TX_LONG;
      else
         brk_len = nine_bit_mode ? uart_ext_pkg::BREAK_TX_SHORT9
                                 : uart_ext_pkg::BREAK_TX_SHORT;
   end

   // break sender counts whole bit times of zero
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         brk_state   <= uart_ext_pkg::BRK_IDLE;
         brk_cnt_reg <= 4'h0;
      end else begin
         unique case (brk_state)
            uart_ext_pkg::BRK_IDLE: begin
               if (send_break) begin
                  brk_state   <= uart_ext_pkg::BRK_SEND;
                  brk_cnt_reg <= brk_len;
               end
            end
            uart_ext_pkg::BRK_SEND: begin
               if (baud_tick) begin
                  if (brk_cnt_reg == 4'h1)
                     brk_state <= uart_ext_pkg::BRK_IDLE;
                  brk_cnt_reg <= brk_cnt_reg - 4'h1;
               end
            end
         endcase
      end
   end
   assign tx_break_active = brk_state == uart_ext_pkg::BRK_SEND;

   // output polarity covers data, start, stop, break and idle
   assign tx_out = (tx_core_bit && !tx_break_active) ^ transmit_invert;

   // single-wire mode: direction bit picks pin drive or listen
   assign single_wire    = loop_select && receive_source;
   assign tx_oe          = single_wire ? single_wire_direction : 1'b1;
   assign single_wire_rx = tx_pin_in;

   // error interrupt: each flag gated by its own enable
   assign error_irq = |({err_flags.overrun, err_flags.noise,
                         err_flags.framing, err_flags.parity} & err_enable_reg);

   // sticky events, write-one clear register, set wins
   assign evt_set = {break_seen && long_break_detect_enable, rx_edge};
   generate
      for (genvar i = 0; i < uart_ext_pkg::EVT_BITS; i++) begin : g_evt
         always_ff @(posedge mclk or negedge nrst) begin
            if (!nrst)
               evt_status_reg[i] <= 1'b0;
            else if (evt_set[i])
               evt_status_reg[i] <= 1'b1;
            else if (reg_write && reg_addr == uart_ext_pkg::ADDR_EVT_CLEAR && reg_wdata[i])
               evt_status_reg[i] <= 1'b0;
         end
      end
   endgenerate

   // event enable register
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst)
         evt_enable_reg <= uart_ext_pkg::RESET_EVT;
      else if (reg_write && reg_addr == uart_ext_pkg::ADDR_EVT_ENABLE)
         evt_enable_reg <= reg_wdata[uart_ext_pkg::EVT_BITS-1:0];
   end
   assign irq = error_irq || |(evt_status_reg & evt_enable_reg);

   // read data one cycle after the strobe, zero otherwise
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst)
         reg_rdata <= uart_ext_pkg::RESET_BYTE;
      else if (!reg_read)
         reg_rdata <= uart_ext_pkg::RESET_BYTE;
      else begin
         unique case (reg_addr)
            uart_ext_pkg::ADDR_STATUS_TWO:
               reg_rdata <= {long_break_irq_flag, receive_edge_irq_flag, 1'b0,
                             receive_invert, wake_idle_detect, long_break_generate,
                             long_break_detect_enable, receiver_active_flag};
            uart_ext_pkg::ADDR_CONTROL_THREE:
               reg_rdata <= {rx_ninth_bit, tx_ninth_bit, single_wire_direction,
                             transmit_invert, err_enable_reg};
            uart_ext_pkg::ADDR_EVT_STATUS:
               reg_rdata <= {6'h00, evt_status_reg};
            uart_ext_pkg::ADDR_EVT_ENABLE:
               reg_rdata <= {6'h00, evt_enable_reg};
            default:
               reg_rdata <= uart_ext_pkg::RESET_BYTE;
         endcase
      end
   end

   // checks next to the guarded logic
   property p_long_break_flag;
      @(posedge mclk) disable iff (!nrst)
      (baud_tick && !rx_line && low_cnt_reg == rx_threshold - 4'h1
       && long_break_detect_enable) |=> long_break_irq_flag;
   endproperty
   a_long_break_flag: assert property (p_long_break_flag)
      else $error("long break flag not set");

   property p_edge_flag;
      @(posedge mclk) disable iff (!nrst)
      ($past(rx_pin ^ receive_invert) && !(rx_pin ^ receive_invert)) |-> ##1 receive_edge_irq_flag;
   endproperty
   a_edge_flag: assert property (p_edge_flag)
      else $error("receive edge flag not set");

   property p_rx_polarity;
      @(posedge mclk) disable iff (!nrst)
      receive_invert |-> rx_line != rx_pin;
   endproperty
   a_rx_polarity: assert property (p_rx_polarity)
      else $error("receive line not inverted");

   property p_idle_standby;
      @(posedge mclk) disable iff (!nrst)
      (receiver_standby && !wake_idle_detect) |-> !idle_flag_set;
   endproperty
   a_idle_standby: assert property (p_idle_standby)
      else $error("idle flag raised in standby");

   property p_break_start;
      @(posedge mclk) disable iff (!nrst)
      (!tx_break_active && send_break) |=> tx_break_active && brk_cnt_reg == $past(brk_len)
                                           && !tx_out == !transmit_invert;
   endproperty
   a_break_start: assert property (p_break_start)
      else $error("break length or level wrong");

   property p_long_detect_blocks;
      @(posedge mclk) disable iff (!nrst)
      long_break_detect_enable |-> !framing_fault_set && !receive_buffer_full_set;
   endproperty
   a_long_detect_blocks: assert property (p_long_detect_blocks)
      else $error("framing or full flag set while long detect on");

   property p_active_flag;
      @(posedge mclk) disable iff (!nrst)
      rx_core.start_valid |=> receiver_active_flag;
   endproperty
   a_active_flag: assert property (p_active_flag)
      else $error("active flag not set on start");

   property p_tx_ninth;
      @(posedge mclk) disable iff (!nrst)
      (data_write && nine_bit_mode) |=> tx_load && tx_load_word[8] == $past(tx_ninth_bit);
   endproperty
   a_tx_ninth: assert property (p_tx_ninth)
      else $error("ninth transmit bit not loaded");

   property p_direction;
      @(posedge mclk) disable iff (!nrst)
      (loop_select && receive_source) |-> tx_oe == single_wire_direction;
   endproperty
   a_direction: assert property (p_direction)
      else $error("single-wire direction wrong");

   property p_error_irq;
      @(posedge mclk) disable iff (!nrst)
      (err_flags.overrun && err_enable_reg[3]) |-> error_irq && irq;
   endproperty
   a_error_irq: assert property (p_error_irq)
      else $error("overrun interrupt missing");
endmodule

// file: test/remote_node.sv
// remote serial node model: drives the receive pin, times transmitted low runs
module remote_node (
   // clock and bit timing
   input  wire logic       mclk,
   input  wire logic       baud_tick,
   // line from the block
   input  wire logic       tx_out,
   // line to the block, and length of the last low run
   output logic            rx_pin,
   output logic      [7:0] last_run
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] run = 8'h00;

   // idle line is high, as a pulled-up receive pin would be
   initial rx_pin = 1'b1;
   initial last_run = 8'h00;

   // count bit times of low on the line, keep the length of the last run
   always @(posedge mclk) begin
      if (tx_out === 1'b0) begin
         if (baud_tick) run <= run + 8'h01;
      end else if (run != 8'h00) begin
         last_run <= run;
         run <= 8'h00;
      end
   end

   // change the line level just after an edge
   task automatic drive(input logic v);
      @(posedge mclk);
      rx_pin <= v;
   endtask

   // hold the line low for n bit times, left low on return
   task automatic low_run(input int n);
      drive(1'b0);
      repeat (n) @(posedge mclk iff baud_tick);
      #1;
   endtask
endmodule

// file: test/testbench.sv
// self-checking bench of the serial status/control extension
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic mclk, nrst, reg_write, reg_read, baud_tick, nine_bit_mode, loop_select;
   logic receive_source, receiver_standby, rx_pin, rx_line, framing_fault_set;
   logic receive_buffer_full_set, idle_flag_set, break_detected, tx_core_bit;
   logic send_break, data_write, tx_load, tx_break_active, tx_out, tx_oe;
   logic tx_pin_in, single_wire_rx, error_irq, irq;
   logic [2:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, data_wdata, last_run;
   logic [3:0] frame_bits;
   logic [8:0] tx_load_word;
   logic [1:0] div;
   uart_ext_pkg::rx_core_t   rxc;
   uart_ext_pkg::err_flags_t errf;
   int num_errors, comparisons, cycles, brk_cnt;

   uart_status2_control3_logic uut (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .baud_tick(baud_tick), .nine_bit_mode(nine_bit_mode),
      .loop_select(loop_select), .receive_source(receive_source),
      .receiver_standby(receiver_standby), .frame_bits(frame_bits), .rx_pin(rx_pin),
      .rx_line(rx_line), .rx_core(rxc), .framing_fault_set(framing_fault_set),
      .receive_buffer_full_set(receive_buffer_full_set), .idle_flag_set(idle_flag_set),
      .break_detected(break_detected), .tx_core_bit(tx_core_bit), .send_break(send_break),
      .data_write(data_write), .data_wdata(data_wdata), .tx_load_word(tx_load_word),
      .tx_load(tx_load), .tx_break_active(tx_break_active), .tx_out(tx_out), .tx_oe(tx_oe),
      .tx_pin_in(tx_pin_in), .single_wire_rx(single_wire_rx), .err_flags(errf),
      .error_irq(error_irq), .irq(irq));

   remote_node node (.mclk(mclk), .baud_tick(baud_tick), .tx_out(tx_out), .rx_pin(rx_pin),
      .last_run(last_run));

   // clock, one bit time every four cycles, break pulse count, hang guard
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      div <= div + 2'h1;
      baud_tick <= (div == 2'h3);
      if (break_detected === 1'b1) brk_cnt <= brk_cnt + 1;
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors++;
         stop_test();
      end
   end

   task automatic chk(input logic [9:0] got, input logic [9:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one-cycle strobes; read data checked in the following cycle only
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge mclk);
      reg_write <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] exp);
      @(posedge mclk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge mclk);
      reg_read <= 1'b0;
      #1 chk(reg_rdata, exp);
   endtask

   // drive one receive core event, compare the gated flag pulses that cycle
   task automatic core(input logic [4:0] v, input logic [2:0] exp);
      @(posedge mclk);
      rxc <= v;
      #1 chk({framing_fault_set, receive_buffer_full_set, idle_flag_set}, exp);
      @(posedge mclk);
      rxc <= 5'h00;
   endtask

   task automatic reset_values;
      rd(3'h0, 8'h00);
      rd(3'h1, 8'h00);
      rd(3'h2, 8'h00);
      rd(3'h4, 8'h00);
      rd(3'h5, 8'h00);
      wr(3'h0, 8'hFF);
      rd(3'h0, 8'h5E);
      wr(3'h0, 8'hC0);
   endtask

   // break threshold for each mode and detect length, flag only with long detect
   task automatic break_detect;
      int b;
      logic [7:0] c;
      for (int k = 0; k < 4; k++) begin
         c = k[1] ? 8'h02 : 8'h00;
         nine_bit_mode <= k[0];
         wr(3'h0, c);
         b = brk_cnt;
         node.low_run(9 + k[0] + k[1]);
         chk(9'(brk_cnt - b), 9'h000);
         node.low_run(1);
         chk(9'(brk_cnt - b), 9'h001);
         node.drive(1'b1);
         rd(3'h0, {k[1], 1'b1, 6'h00} | c);
         wr(3'h0, 8'hC0 | c);
         rd(3'h0, c);
      end
      rd(3'h2, 8'h03);
      wr(3'h3, 8'h03);
      wr(3'h0, 8'h00);
   endtask

   // transmitted break length for every length select and mode
   task automatic break_send;
      for (int k = 0; k < 4; k++) begin
         nine_bit_mode <= k[0];
         wr(3'h0, k[1] ? 8'h04 : 8'h00);
         @(posedge mclk);
         send_break <= 1'b1;
         @(posedge mclk);
         send_break <= 1'b0;
         #1 chk(tx_break_active, 1'b1);
         for (int i = 0; i < 100 && tx_break_active === 1'b1; i++) @(posedge mclk);
         repeat (2) @(posedge mclk);
         chk(last_run, 10 + k[0] + 3 * k[1]);
      end
      wr(3'h0, 8'h00);
   endtask

   // active edge with and without receive inversion, interrupt enable and mask
   task automatic edges;
      wr(3'h4, 8'h01);
      node.drive(1'b0);
      rd(3'h0, 8'h40);
      chk(irq, 1'b1);
      rd(3'h2, 8'h01);
      wr(3'h0, 8'h40);
      wr(3'h3, 8'h01);
      rd(3'h2, 8'h00);
      chk(irq, 1'b0);
      node.drive(1'b1);
      rd(3'h0, 8'h00);
      wr(3'h0, 8'h10);
      wr(3'h0, 8'h50);
      #1 chk(rx_line, 1'b0);
      node.drive(1'b0);
      rd(3'h0, 8'h10);
      node.drive(1'b1);
      rd(3'h0, 8'h50);
      wr(3'h0, 8'h40);
      wr(3'h3, 8'h01);
      wr(3'h4, 8'h00);
      node.drive(1'b0);
      rd(3'h0, 8'h40);
      chk(irq, 1'b0);
      wr(3'h0, 8'h40);
      node.drive(1'b1);
   endtask

   // receive gating, active flag and the received ninth bit
   task automatic rx_gating;
      core(5'h10, 3'h0);
      rd(3'h0, 8'h01);
      core(5'h08, 3'h1);
      rd(3'h0, 8'h00);
      nine_bit_mode <= 1'b1;
      wr(3'h0, 8'h04);
      core(5'h07, 3'h6);
      rd(3'h1, 8'h80);
      wr(3'h0, 8'h02);
      core(5'h06, 3'h0);
      rd(3'h1, 8'h80);
      wr(3'h0, 8'h00);
      receiver_standby <= 1'b1;
      core(5'h08, 3'h0);
      wr(3'h0, 8'h08);
      core(5'h08, 3'h1);
      receiver_standby <= 1'b0;
      wr(3'h0, 8'h00);
   endtask

   // error interrupt enables, frame length, pin control and ninth transmit bit
   task automatic tx_side;
      for (int i = 0; i < 4; i++) begin
         wr(3'h1, 8'(1 << i));
         errf <= 4'(1 << i);
         #1 @(posedge mclk) #1 chk({error_irq, irq}, 2'h3);
         errf <= ~4'(1 << i);
         @(posedge mclk) #1 chk(error_irq, 1'b0);
      end
      errf <= 4'h0;
      nine_bit_mode <= 1'b0;
      #1 @(posedge mclk) #1 chk(frame_bits, 4'hA);
      nine_bit_mode <= 1'b1;
      loop_select <= 1'b1;
      receive_source <= 1'b1;
      wr(3'h1, 8'h10);
      #1 chk({tx_out, tx_oe, single_wire_rx}, 3'h0);
      chk(frame_bits, 4'hB);
      wr(3'h1, 8'h60);
      #1 chk({tx_out, tx_oe}, 2'h3);
      for (int m = 1; m >= 0; m--) begin
         nine_bit_mode <= m[0];
         @(posedge mclk);
         data_write <= 1'b1;
         data_wdata <= m[0] ? 8'hA5 : 8'h5A;
         @(posedge mclk);
         data_write <= 1'b0;
         #1 chk({tx_load, tx_load_word}, {1'b1, m[0], m[0] ? 8'hA5 : 8'h5A});
      end
      // shifter bit and pin input reach the pins; direction only matters in single-wire mode
      tx_core_bit <= 1'b0;
      tx_pin_in <= 1'b1;
      wr(3'h1, 8'h10);
      #1 chk({tx_out, tx_oe, single_wire_rx}, 3'h5);
      loop_select <= 1'b0;
      #1 chk(tx_oe, 1'b1);
      loop_select <= 1'b1;
      receive_source <= 1'b0;
      #1 chk(tx_oe, 1'b1);
   endtask

   task automatic stop_test;
      if (num_errors == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      {nrst, reg_write, reg_read, baud_tick, nine_bit_mode, loop_select} = 6'h00;
      {receive_source, receiver_standby, send_break, data_write, tx_pin_in} = 5'h00;
      {reg_addr, reg_wdata, data_wdata, div} = 21'h000000;
      tx_core_bit = 1'b1;
      rxc = 5'h00;
      errf = 4'h0;
      {num_errors, comparisons, cycles, brk_cnt} = {4{32'h0}};
      repeat (2) @(posedge mclk);
      nrst <= 1'b1;
      reset_values();
      break_detect();
      break_send();
      edges();
      rx_gating();
      tx_side();
      stop_test();
   end
endmodule
